/* File: rtl/pspc_power_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module pspc_power_ctrl
  import pspc_pkg::*;
#(
  parameter int NCORES   = 4,
  parameter int NTHREADS = 2,
  parameter int NLINKS   = 2
)(
  input  wire logic                           clk,
  input  wire logic                           rstn,
  input  wire logic [NCORES*NTHREADS*CST_W-1:0] threadReq,
  input  wire logic [NCORES-1:0]              wakeIrq,
  input  wire logic [NCORES-1:0]              wakeMonitor,
  input  wire logic [NCORES-1:0]              wakeDeadline,
  input  wire logic [NCORES-1:0]              coreFlushDone,
  input  wire logic [NCORES-1:0]              coreSaveDone,
  input  wire logic [NCORES-1:0]              coreRestoreDone,
  input  wire logic                           llcEmpty,
  input  wire logic                           memIdle,
  input  wire logic                           bankOpen,
  input  wire logic [NLINKS-1:0]              linkIdleReq,
  input  wire logic                           sysReqValid,
  input  wire logic [2:0]                     sysReqCode,
  input  wire logic                           sysWake,
  output var  logic [NCORES*CST_W-1:0]        coreState,
  output logic      [NCORES-1:0]              coreHalt,
  output logic      [NCORES-1:0]              coreLowVf,
  output logic      [NCORES-1:0]              coreFlushReq,
  output logic      [NCORES-1:0]              coreClkOn,
  output logic      [NCORES-1:0]              coreSaveReq,
  output logic      [NCORES-1:0]              coreVccOn,
  output logic      [NCORES-1:0]              coreRestoreReq,
  output logic      [NCORES-1:0]              coreRun,
  output var  logic [2:0]                     pkgState,
  output logic                                llcFlushReq,
  output logic                                llcPwrOn,
  output logic                                baseClkOn,
  output logic                                graphicsDomainOn,
  output logic                                systemAgentDomainOn,
  output logic                                ioPwrOn,
  output logic                                regulatorDeepestPhaseState,
  output logic                                regulatorLowPowerMode,
  output logic                                refClk24On,
  output var  logic                           cke,
  output var  logic                           srCmd,
  output var  logic [NLINKS*2-1:0]            linkState,
  output var  logic [1:0]                     sysState,
  output var  logic                           sysReject,
  output var  logic                           sysClkOn
);

  // Reset release chain; assert is immediate, release is clocked
  logic [RST_SYNC_STAGES-1:0] rstSync;
  logic                       rstnQ;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rstSync <= '0;
    else
      rstSync <= {rstSync[RST_SYNC_STAGES-2:0], 1'b1};
  end
  assign rstnQ = rstSync[RST_SYNC_STAGES-1];

  pspc_pkg_t pkg;           // Package state register
  pspc_pkg_t next_pkg;      // Package next state
  pspc_pkg_t pkgTarget;     // Deepest state cores allow
  pspc_sys_t sys;           // System sleep state
  pspc_mem_t mem;           // Memory clock-enable state
  pspc_mem_t next_mem;      // Memory next state
  logic [NCORES-1:0] shallow;  // Core above C3
  logic [NCORES-1:0] clkGate;  // Core clocks gated
  logic [NCORES-1:0] vccOff;   // Core supply removed
  logic [CST_W-1:0]  minCore;  // Shallowest core code, C0 included

  // Per-core resolution, wake and power sequencing
  genvar gc;
  generate
    for (gc = 0; gc < NCORES; gc++)
    begin : gCore
      logic [CST_W-1:0] resolved;  // Lowest thread request
      logic [CST_W-1:0] cst;       // Registered core state
      logic             wakeHold;  // Keep C0 until threads agree
      logic             restoring; // Saved state being reloaded
      logic             wake;

      // Lowest request wins; codes past C10 clamp to C10
      always_comb
      begin
        resolved = CST_C10;
        for (int t = 0; t < NTHREADS; t++)
        begin
          if (threadReq[(gc*NTHREADS+t)*CST_W +: CST_W] < resolved)
            resolved = threadReq[(gc*NTHREADS+t)*CST_W +: CST_W];
        end
      end

      assign wake = wakeIrq[gc] | wakeMonitor[gc] | wakeDeadline[gc];

      // Wake forces C0 and holds it; set beats clear
      always_ff @(posedge clk or negedge rstnQ)
      begin
        if (!rstnQ)
          wakeHold <= 1'b0;
        else if (wake)
          wakeHold <= 1'b1;
        else if (resolved == CST_C0)
          wakeHold <= 1'b0;
      end

      // Core state follows request unless a wake is pending
      always_ff @(posedge clk or negedge rstnQ)
      begin
        if (!rstnQ)
          cst <= CST_C0;
        else if (wake || wakeHold)
          cst <= CST_C0;
        else if (resolved == 4'h4 || resolved == 4'h5)
          cst <= CST_C3;  // Unassigned codes act as C3
        else
          cst <= resolved;
      end

      // Clocks gate only after the cache write-back completes
      always_ff @(posedge clk or negedge rstnQ)
      begin
        if (!rstnQ)
          clkGate[gc] <= 1'b0;
        else if (cst >= CST_C3 && coreFlushDone[gc])
          clkGate[gc] <= 1'b1;
        else if (cst < CST_C3 && !vccOff[gc] && !restoring)
          clkGate[gc] <= 1'b0;
      end

      // Supply drops after save; returns once base clock is back
      always_ff @(posedge clk or negedge rstnQ)
      begin
        if (!rstnQ)
          vccOff[gc] <= 1'b0;
        else if (cst >= CST_C6 && clkGate[gc] && coreSaveDone[gc])
          vccOff[gc] <= 1'b1;
        else if (cst < CST_C6 && pkg < PK_C6)
          vccOff[gc] <= 1'b0;
      end

      // Restore runs between power-up and clock release
      always_ff @(posedge clk or negedge rstnQ)
      begin
        if (!rstnQ)
          restoring <= 1'b0;
        else if (vccOff[gc] && cst < CST_C6 && pkg < PK_C6)
          restoring <= 1'b1;
        else if (coreRestoreDone[gc])
          restoring <= 1'b0;
      end

      assign coreState[gc*CST_W +: CST_W] = cst;
      assign shallow[gc]        = cst < CST_C3;
      assign coreHalt[gc]       = cst != CST_C0;
      assign coreLowVf[gc]      = cst == CST_C1E;
      assign coreFlushReq[gc]   = cst >= CST_C3 && !clkGate[gc];
      assign coreClkOn[gc]      = !clkGate[gc];
      assign coreSaveReq[gc]    = cst >= CST_C6 && clkGate[gc] && !vccOff[gc];
      assign coreVccOn[gc]      = !vccOff[gc];
      assign coreRestoreReq[gc] = restoring;
      // Resume only with clocks, supply and state all back
      assign coreRun[gc] = cst == CST_C0 && !clkGate[gc] && !vccOff[gc] && !restoring;
    end
  endgenerate

  // Shallowest core code decides the package target
  always_comb
  begin
    minCore = CST_C10;
    for (int c = 0; c < NCORES; c++)
    begin
      if (coreState[c*CST_W +: CST_W] < minCore)
        minCore = coreState[c*CST_W +: CST_W];
    end
  end

  // Map core code to package depth; any core above C3 keeps C0
  always_comb
  begin
    if (|shallow)
      pkgTarget = PK_C0;
    else if (minCore >= CST_C10)
      pkgTarget = PK_C10;
    else if (minCore >= CST_C9)
      pkgTarget = PK_C9;
    else if (minCore >= CST_C8)
      pkgTarget = PK_C8;
    else if (minCore >= CST_C7)
      pkgTarget = PK_C7;
    else if (minCore >= CST_C6)
      pkgTarget = PK_C6;
    else
      pkgTarget = PK_C3;
  end

  // One step per cycle; entry waits on core and cache handshakes
  always_comb
  begin
    next_pkg = pkg;
    if (pkgTarget < pkg)
      next_pkg = pspc_pkg_t'(pkg - 3'h1);
    else if (pkgTarget > pkg)
    begin
      case (pkg)
        PK_C0:   next_pkg = PK_C2;
        PK_C2:   if (&clkGate) next_pkg = PK_C3;
        PK_C3:   if (&vccOff) next_pkg = PK_C6;
        PK_C6:   next_pkg = PK_C7;
        PK_C7:   if (llcEmpty) next_pkg = PK_C8;
        PK_C8:   next_pkg = PK_C9;
        PK_C9:   next_pkg = PK_C10;
        default: next_pkg = PK_C10;
      endcase
    end
  end

  // Package state register
  always_ff @(posedge clk or negedge rstnQ)
  begin
    if (!rstnQ)
      pkg <= PK_C0;
    else
      pkg <= next_pkg;
  end

  // Package level actions from depth; the cache outputs also use llcEmpty
  assign pkgState            = pkg;
  assign baseClkOn           = pkg < PK_C6;
  assign llcFlushReq         = pkg >= PK_C7 && !llcEmpty;
  assign llcPwrOn            = !(pkg >= PK_C7 && llcEmpty);
  assign graphicsDomainOn    = pkg < PK_C9;
  assign systemAgentDomainOn = pkg < PK_C9;
  assign ioPwrOn             = 1'b1;
  assign regulatorDeepestPhaseState = pkg == PK_C10;
  assign regulatorLowPowerMode      = pkg == PK_C10;
  assign refClk24On          = pkg != PK_C10;

  // Memory: package C2 keeps path open, C3+ or S3 self-refreshes
  logic wantSr;
  logic wantPd;
  assign wantSr = pkg >= PK_C3 || sys == SYS_S3;
  assign wantPd = memIdle && !wantSr;

  always_comb
  begin
    next_mem = mem;
    case (mem)
      MEM_UP:
        if (wantSr)
          next_mem = MEM_SRE;
        else if (wantPd && bankOpen)
          next_mem = MEM_APD;
        else if (wantPd)
          next_mem = MEM_PPD;
      MEM_PPD, MEM_APD:
        if (!wantPd)
          next_mem = MEM_UP;
      MEM_SRE:
        next_mem = MEM_SR;
      default:
        if (!wantSr)
          next_mem = MEM_UP;
    endcase
  end

  // CKE high only in power up and the command cycle
  always_ff @(posedge clk or negedge rstnQ)
  begin
    if (!rstnQ)
    begin
      mem   <= MEM_UP;
      cke   <= 1'b1;
      srCmd <= 1'b0;
    end
    else
    begin
      mem   <= next_mem;
      cke   <= next_mem == MEM_UP || next_mem == MEM_SRE;
      srCmd <= next_mem == MEM_SRE;
    end
  end

  // Sleep requests; the hot suspend form is refused
  always_ff @(posedge clk or negedge rstnQ)
  begin
    if (!rstnQ)
    begin
      sys       <= SYS_S0;
      sysReject <= 1'b0;
    end
    else
    begin
      sysReject <= sysReqValid && sysReqCode == SREQ_S3HOT;
      if (sysWake)
        sys <= SYS_S0;
      else if (sysReqValid && sys == SYS_S0)
      begin
        if (sysReqCode == SREQ_S3COLD)
          sys <= SYS_S3;
        else if (sysReqCode == SREQ_S4)
          sys <= SYS_S4;
        else if (sysReqCode == SREQ_S5)
          sys <= SYS_S5;
      end
    end
  end

  // System clocks follow the sleep state, not package depth
  always_ff @(posedge clk or negedge rstnQ)
  begin
    if (!rstnQ)
      sysClkOn <= 1'b1;
    else
      sysClkOn <= sys == SYS_S0;
  end
  assign sysState = sys;

  // Link states; sleep powers links off
  genvar gl;
  generate
    for (gl = 0; gl < NLINKS; gl++)
    begin : gLink
      always_ff @(posedge clk or negedge rstnQ)
      begin
        if (!rstnQ)
          linkState[gl*2 +: 2] <= LNK_L0;
        else if (sys != SYS_S0)
          linkState[gl*2 +: 2] <= LNK_L3;
        else if (linkIdleReq[gl])
          linkState[gl*2 +: 2] <= LNK_L1;
        else
          linkState[gl*2 +: 2] <= LNK_L0;
      end
    end
  endgenerate

endmodule
`default_nettype wire

/* File: common/pspc_pkg.sv */
`default_nettype none
package pspc_pkg;
  // Idle state request codes, numeric order equals depth
  localparam logic [3:0] CST_C0  = 4'h0;
  localparam logic [3:0] CST_C1  = 4'h1;
  localparam logic [3:0] CST_C1E = 4'h2;
  localparam logic [3:0] CST_C3  = 4'h3;
  localparam logic [3:0] CST_C6  = 4'h6;
  localparam logic [3:0] CST_C7  = 4'h7;
  localparam logic [3:0] CST_C8  = 4'h8;
  localparam logic [3:0] CST_C9  = 4'h9;
  localparam logic [3:0] CST_C10 = 4'hA;
  localparam int         CST_W   = 4;

  // Sleep request codes
  localparam logic [2:0] SREQ_S0     = 3'h0;
  localparam logic [2:0] SREQ_S3COLD = 3'h1;
  localparam logic [2:0] SREQ_S3HOT  = 3'h2;
  localparam logic [2:0] SREQ_S4     = 3'h3;
  localparam logic [2:0] SREQ_S5     = 3'h4;

  // Link power state codes on the ports
  localparam logic [1:0] LNK_L0 = 2'h0;
  localparam logic [1:0] LNK_L1 = 2'h1;
  localparam logic [1:0] LNK_L3 = 2'h3;

  // Reset synchroniser depth
  localparam int RST_SYNC_STAGES = 2;

  // Package states in depth order; comparisons rely on it
  typedef enum logic [2:0] {PK_C0, PK_C2, PK_C3, PK_C6, PK_C7, PK_C8, PK_C9, PK_C10} pspc_pkg_t;
  // Memory controller clock-enable states
  typedef enum logic [2:0] {MEM_UP, MEM_PPD, MEM_APD, MEM_SRE, MEM_SR} pspc_mem_t;
  // System sleep states
  typedef enum logic [1:0] {SYS_S0, SYS_S3, SYS_S4, SYS_S5} pspc_sys_t;
endpackage
`default_nettype wire

/* File: dv/pspc_power_ctrl_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module pspc_power_ctrl_chk
  import pspc_pkg::*;
#(
  parameter int NCORES   = 4,
  parameter int NTHREADS = 2,
  parameter int NLINKS   = 2
)(
  input wire logic              clk,
  input wire logic              rstn,
  input wire logic              llcEmpty,
  input wire logic              memIdle,
  input wire logic [NCORES-1:0] coreClkOn,
  input wire logic [NCORES-1:0] coreVccOn,
  input wire logic [NCORES-1:0] coreRun,
  input wire logic [2:0]        pkgState,
  input wire logic              baseClkOn,
  input wire logic              graphicsDomainOn,
  input wire logic              systemAgentDomainOn,
  input wire logic              ioPwrOn,
  input wire logic              refClk24On,
  input wire logic              cke,
  input wire logic              srCmd,
  input wire logic [1:0]        sysState,
  input wire logic              sysClkOn
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Self-refresh is commanded with the clock enable still high
  sequence srEnter; srCmd && cke; endsequence
  sequence srHold; !cke; endsequence
  srOrder_a: assert property (srCmd |-> srEnter ##1 srHold)
    else $error("self refresh order broken");
  pdIdle_a: assert property ($fell(cke) && !$past(srCmd) |-> $past(memIdle))
    else $error("power down while memory busy");
  // Package moves at most one step per edge
  pkgStep_a: assert property ($changed(pkgState) |->
    (4'(pkgState) == 4'($past(pkgState)) + 4'h1) || (4'(pkgState) + 4'h1 == 4'($past(pkgState))))
    else $error("package skipped a step");
  c3Gate_a: assert property (pkgState == 3'h2 && $past(pkgState) == 3'h1 |->
    $past(coreClkOn) == '0) else $error("deep sleep with core clock on");
  c6Vcc_a: assert property (pkgState == 3'h3 && $past(pkgState) == 3'h2 |->
    $past(coreVccOn) == '0 && !baseClkOn) else $error("power down with core supply on");
  c8Llc_a: assert property (pkgState == 3'h5 && $past(pkgState) == 3'h4 |-> $past(llcEmpty))
    else $error("cache not flushed before deeper state");
  c9Rail_a: assert property (pkgState >= 3'h6 |->
    !graphicsDomainOn && !systemAgentDomainOn && ioPwrOn) else $error("uncore rails wrong");
  c10Ref_a: assert property (pkgState == 3'h7 |-> !refClk24On)
    else $error("reference clock on in deepest state");
  sleepClk_a: assert property (sysState != 2'h0 && $past(sysState) != 2'h0 |-> !sysClkOn)
    else $error("system clock on in sleep");
  // A running core needs its own rails and clocks and the package clocks back
  resume_a: assert property (|coreRun |-> baseClkOn && refClk24On &&
    (coreRun & ~(coreVccOn & coreClkOn)) == '0) else $error("core runs before restore");
endmodule
bind pspc_power_ctrl pspc_power_ctrl_chk #(.NCORES(NCORES), .NTHREADS(NTHREADS),
  .NLINKS(NLINKS)) u_chk (.*);
`default_nettype wire

/* File: dv/pspc_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pspc_core_model #(
  parameter int NCORES = 4
)(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              slow,
  input  wire logic [NCORES-1:0] coreFlushReq,
  input  wire logic [NCORES-1:0] coreSaveReq,
  input  wire logic [NCORES-1:0] coreRestoreReq,
  input  wire logic [NCORES-1:0] coreRun,
  input  wire logic              llcFlushReq,
  output logic      [NCORES-1:0] coreFlushDone,
  output logic      [NCORES-1:0] coreSaveDone,
  output logic      [NCORES-1:0] coreRestoreDone,
  output logic                   llcEmpty
);
  logic [3:0] age [3][NCORES]; // Cycles each request has stood
  logic [3:0] llcAge;          // Cycles the cache flush has stood
  logic [3:0] lat;             // Answer latency, longer when slow
  assign lat = slow ? 4'h4 : 4'h1;
  // Saturating so a long stay in a deep state cannot wrap
  function automatic logic [3:0] sat(input logic [3:0] v);
    return (v == 4'hF) ? v : v + 4'h1;
  endfunction
  // Ages restart whenever a request drops
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      age <= '{default: '{default: 4'h0}};
      llcAge <= 4'h0;
      llcEmpty <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < NCORES; i++)
      begin
        age[0][i] <= coreFlushReq[i] ? sat(age[0][i]) : 4'h0;
        age[1][i] <= coreSaveReq[i] ? sat(age[1][i]) : 4'h0;
        age[2][i] <= coreRestoreReq[i] ? sat(age[2][i]) : 4'h0;
      end
      llcAge <= llcFlushReq ? sat(llcAge) : 4'h0;
      // Cache stays clean until some core runs again
      if (llcAge > lat + 4'h2)
        llcEmpty <= 1'b1;
      else if (|coreRun)
        llcEmpty <= 1'b0;
    end
  end
  // Done is a level that stands while its request stands
  always_comb
  begin
    for (int i = 0; i < NCORES; i++)
    begin
      coreFlushDone[i] = coreFlushReq[i] && age[0][i] >= lat;
      coreSaveDone[i] = coreSaveReq[i] && age[1][i] >= lat;
      coreRestoreDone[i] = coreRestoreReq[i] && age[2][i] >= lat;
    end
  end
endmodule
`default_nettype wire

/* File: dv/package_power_state_control_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module package_power_state_control_tb_top
  import pspc_pkg::*;
;
  localparam int NC = 2; // Cores
  localparam int NT = 2; // Threads per core
  logic clk = 1'b0, rstn = 1'b0, slow = 1'b0;
  logic [NC*NT*CST_W-1:0] threadReq = '0;
  logic [NC-1:0] wakeIrq = '0, wakeMonitor = '0, wakeDeadline = '0;
  logic memIdle = 1'b0, bankOpen = 1'b0, sysReqValid = 1'b0, sysWake = 1'b0;
  logic [1:0] linkIdleReq = '0;
  logic [2:0] sysReqCode = '0;
  logic [NC-1:0] coreFlushDone, coreSaveDone, coreRestoreDone, coreHalt, coreLowVf;
  logic [NC-1:0] coreFlushReq, coreClkOn, coreSaveReq, coreVccOn, coreRestoreReq, coreRun;
  logic [NC*CST_W-1:0] coreState;
  logic [2:0] pkgState;
  logic llcEmpty, llcFlushReq, llcPwrOn, baseClkOn, graphicsDomainOn, systemAgentDomainOn;
  logic ioPwrOn, regulatorDeepestPhaseState, regulatorLowPowerMode, refClk24On;
  logic cke, srCmd, sysReject, sysClkOn;
  logic [3:0] linkState;
  logic [1:0] sysState;
  int err_total = 0;
  int tests_run = 0;
  pspc_power_ctrl #(.NCORES(NC), .NTHREADS(NT), .NLINKS(2)) dut (
    .clk, .rstn, .threadReq, .wakeIrq, .wakeMonitor, .wakeDeadline, .coreFlushDone,
    .coreSaveDone, .coreRestoreDone, .llcEmpty, .memIdle, .bankOpen, .linkIdleReq,
    .sysReqValid, .sysReqCode, .sysWake, .coreState, .coreHalt, .coreLowVf, .coreFlushReq,
    .coreClkOn, .coreSaveReq, .coreVccOn, .coreRestoreReq, .coreRun, .pkgState,
    .llcFlushReq, .llcPwrOn, .baseClkOn, .graphicsDomainOn, .systemAgentDomainOn, .ioPwrOn,
    .regulatorDeepestPhaseState, .regulatorLowPowerMode, .refClk24On, .cke, .srCmd,
    .linkState, .sysState, .sysReject, .sysClkOn);
  pspc_core_model #(.NCORES(NC)) u_model (
    .clk, .rstn, .slow, .coreFlushReq, .coreSaveReq, .coreRestoreReq, .coreRun,
    .llcFlushReq, .coreFlushDone, .coreSaveDone, .coreRestoreDone, .llcEmpty);
  // 50 MHz clock
  initial
    forever #10 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("mismatches=%0d checks=%0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Codes above the deepest clamp; the two unused codes act as C3
  function automatic logic [3:0] mapc(input logic [3:0] v);
    if (v > CST_C10)
      return CST_C10;
    return (v == 4'h4 || v == 4'h5) ? CST_C3 : v;
  endfunction
  // Shallowest thread request wins
  function automatic logic [3:0] resolve(input int c);
    logic [3:0] m = CST_C10;
    for (int t = 0; t < NT; t++)
      if (mapc(threadReq[(c*NT+t)*4 +: 4]) < m)
        m = mapc(threadReq[(c*NT+t)*4 +: 4]);
    return m;
  endfunction
  task automatic setAll(input logic [3:0] v);
    @(posedge clk);
    threadReq <= {NC*NT{v}};
  endtask
  task automatic sysPulse(input logic [2:0] code);
    @(posedge clk);
    sysReqValid <= 1'b1;
    sysReqCode <= code;
    @(posedge clk);
    sysReqValid <= 1'b0;
  endtask
  // Bounded wait for a package state, optionally with all cores running
  task automatic settle(input logic [2:0] s, input logic run);
    int n = 0;
    while (!(pkgState === s && (!run || &coreRun === 1'b1)))
    begin
      @(posedge clk);
      #1;
      n++;
      if (n > 400)
      begin
        err_total++;
        summarize();
      end
    end
  endtask
  initial
  begin
    void'($urandom(32'hA2307FF9));
    cyc(4);
    rstn <= 1'b1;
    cyc(3);
    // Random thread mixes, first one a hand-picked corner
    for (int n = 0; n < 24; n++)
    begin
      threadReq <= (n == 0) ? 16'hFF23 : 16'($urandom);
      slow <= 1'($urandom);
      @(posedge clk);
      #1;
      for (int c = 0; c < NC; c++)
      begin
        chk(coreState[c*4 +: 4], resolve(c));
        chk(coreHalt[c], resolve(c) != CST_C0);
        chk(coreLowVf[c], resolve(c) == CST_C1E);
      end
      @(posedge clk);
    end
    // Each wake source pulls a sleeping core back and holds it
    for (int k = 0; k < 3; k++)
    begin
      setAll(CST_C6);
      cyc(20);
      wakeIrq[0] <= (k == 0);
      wakeMonitor[0] <= (k == 1);
      wakeDeadline[0] <= (k == 2);
      @(posedge clk);
      wakeIrq <= '0;
      wakeMonitor <= '0;
      wakeDeadline <= '0;
      #1 chk(coreState[3:0], CST_C0);
      cyc(3);
      #1 chk(coreState[3:0], CST_C0);
      setAll(CST_C0);
      cyc(2);
    end
    // Full descent to the deepest state with a slow far side, then back
    slow <= 1'b1;
    setAll(CST_C10);
    settle(3'h7, 1'b0);
    chk({coreClkOn, coreVccOn}, 8'h00);
    chk({baseClkOn, llcPwrOn, graphicsDomainOn, systemAgentDomainOn}, 8'h00);
    chk({refClk24On, regulatorDeepestPhaseState | regulatorLowPowerMode}, 8'h01);
    chk({ioPwrOn, sysClkOn, cke}, 8'h06);
    // Every handshake request is withdrawn once its answer has come
    chk({coreFlushReq, coreSaveReq, coreRestoreReq, llcFlushReq}, 8'h00);
    setAll(CST_C0);
    settle(3'h0, 1'b1);
    chk({coreVccOn, coreClkOn}, 8'h0F);
    // Both power-down modes, then back to power-up
    for (int b = 0; b < 2; b++)
    begin
      @(posedge clk);
      bankOpen <= b[0];
      memIdle <= 1'b1;
      cyc(3);
      #1 chk({cke, srCmd}, 8'h00);
      @(posedge clk);
      memIdle <= 1'b0;
      cyc(3);
      #1 chk(cke, 1'b1);
    end
    // Hot suspend refused, the other sleep states taken and left
    sysPulse(SREQ_S3HOT);
    #1 chk({sysReject, sysState}, 8'h04);
    for (int k = 1; k < 4; k++)
    begin
      sysPulse((k == 1) ? SREQ_S3COLD : ((k == 2) ? SREQ_S4 : SREQ_S5));
      #1 chk(sysState, k[1:0]);
      cyc(2);
      #1 chk({sysClkOn, linkState}, 8'h0F);
      @(posedge clk);
      sysWake <= 1'b1;
      @(posedge clk);
      sysWake <= 1'b0;
      cyc(2);
      #1 chk({sysClkOn, sysState}, 8'h04);
    end
    // Random link idle requests in the working state
    for (int n = 0; n < 8; n++)
    begin
      @(posedge clk);
      linkIdleReq <= 2'($urandom);
      @(posedge clk);
      #1;
      for (int l = 0; l < 2; l++)
        chk(linkState[l*2 +: 2], linkIdleReq[l] ? LNK_L1 : LNK_L0);
    end
    // Reset in mid-descent returns core state, coreRun, cke, sysClkOn and package state to idle values
    setAll(CST_C10);
    cyc(10);
    rstn <= 1'b0;
    threadReq <= '0;
    cyc(4);
    #1 chk({coreRun, cke, sysClkOn, pkgState}, 8'h78);
    chk(coreState, 8'h00);
    @(posedge clk);
    rstn <= 1'b1;
    cyc(3);
    #1 chk({coreRun, cke, sysClkOn, pkgState}, 8'h78);
    summarize();
  end
endmodule
`default_nettype wire
